// ===== tb/dssc_host.sv
module dssc_host (
   output logic sclk,
   output logic chip_select_n,
   output logic si,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'h0;
      chip_select_n = 1'h1;
      si = 1'h0;
   end
   task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
      r = '0;
      chip_select_n = 1'h0;
      #32;
      for (int i = n - 1; i >= 0; i--) begin
         si = w[i];
         #16 sclk = 1'h1;
         // Sample late in the high phase, after the falling-edge shift has settled
         #14 r = {r[30:0], so};
         #2 sclk = 1'h0;
      end
      #16 chip_select_n = 1'h1;
      // Released line must not keep its last value
      si = ~si;
      #80;
   endtask
endmodule

// ===== tb/tb.sv
module tb import dssc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, sys_rst = 1'h1, vdd_fail = 1'h0;
   logic sclk, chip_select_n, si, so, so_oe_n;
   logic [1:0] direct_in = 2'h3;
   logic [1:0] switch_on, retry_limit_off, retry_off, supply_short_protect_off;
   logic [1:0] on_openload_off, led_openload_threshold, off_openload_off;
   logic [1:0] sense_ratio_high, xenon_profile_off, alt_high_level_sel, overcurrent_mode_sel;
   logic [1:0][1:0] cooling_speed, inrush_speed, steady_level;
   logic vdd_fail_det_en, pwm_en, pwm_clk_internal, sense_tristate, current_mirror_en;
   logic temp_report_en, mirror_output, mirror_select_valid, overvoltage_protect_off;
   logic [8:0] cal_value;
   logic [31:0] rx;
   logic por = 1'h0;
   logic [5:0] flt0 = 6'h00;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   dssc_top i_dut (.mclk, .sys_rst, .sclk, .chip_select_n, .si, .so, .so_oe_n, .direct_in,
      .vdd_fail, .por_event(por), .uv_flag(1'h0), .ov_flag(1'h0),
      .fault_flags_zero(flt0), .fault_flags_one(~flt0), .switch_on, .retry_limit_off,
      .retry_off, .supply_short_protect_off, .on_openload_off, .led_openload_threshold,
      .off_openload_off, .sense_ratio_high, .xenon_profile_off, .cooling_speed,
      .inrush_speed, .alt_high_level_sel, .steady_level, .overcurrent_mode_sel,
      .vdd_fail_det_en, .pwm_en, .pwm_clk_internal, .sense_tristate, .current_mirror_en,
      .temp_report_en, .mirror_output, .mirror_select_valid, .overvoltage_protect_off,
      .cal_value);
   dssc_host i_host (.sclk, .chip_select_n, .si, .so);
   initial forever #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_mismatch++;
         final_report();
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(string n, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   function logic [15:0] fw(logic w, logic p, logic o, logic [2:0] a, logic [8:0] d);
      return {w, p, o, a, 1'h0, d};
   endfunction
   task xf(logic [31:0] w, int n);
      // Keep pin changes off the sampling edge
      @(posedge mclk) #1;
      i_host.xfer(w, n, rx);
   endtask
   task frm(logic [15:0] w);
      xf({16'h0000, w}, 16);
   endtask
   task t_reset;
      chk("oe", so_oe_n, 1'h1);
      chk("fault", {retry_limit_off, retry_off, supply_short_protect_off, sense_ratio_high}, 0);
      chk("ocr", {cooling_speed[0], inrush_speed[0], steady_level[0]}, {DSSC_COOL_MED, DSSC_INR_SLOW, DSSC_LVL2});
      chk("gcr", {sense_tristate, pwm_en, overvoltage_protect_off}, 3'h4);
      $display("test reset done");
   endtask
   task t_fault;
      frm(fw(1'h1, 1'h0, 1'h0, DSSC_A_STAT, 9'h00B));
      frm(fw(1'h0, 1'h1, 1'h1, DSSC_A_FAULT, 9'h07F));
      chk("ret1", rx[15:0], {1'h1, 5'h0B, 1'h1, 9'h000});
      chk("fault", {retry_limit_off, retry_off, supply_short_protect_off, on_openload_off, off_openload_off, sense_ratio_high}, 12'hAAA);
      chk("led", led_openload_threshold, 2'h0);
      frm(fw(1'h1, 1'h1, 1'h0, DSSC_A_FAULT, 9'h002));
      chk("ret2", rx[15:0], {1'h0, 5'h0B, 1'h1, 9'h07F});
      chk("led2", led_openload_threshold, 2'h1);
      chk("oe2", so_oe_n, 1'h1);
      $display("test fault done");
   endtask
   task automatic t_ocr;
      logic [1:0] cl [4] = '{DSSC_COOL_MED, DSSC_COOL_SLOW, DSSC_COOL_FAST, DSSC_COOL_MED};
      logic [1:0] ir [4] = '{DSSC_INR_SLOW, DSSC_INR_FAST, DSSC_INR_MED, DSSC_INR_VSLOW};
      logic [1:0] sl [4] = '{DSSC_LVL2, DSSC_LVL3, DSSC_LVL4, DSSC_LVL1};
      logic [1:0] k;
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         frm(fw(1'h0, 1'h1, 1'h0, DSSC_A_OC, {k[0], k, k, k[1], k, k[0]}));
         chk("cool", cooling_speed[0], cl[i]);
         chk("inr", inrush_speed[0], ir[i]);
         chk("stdy", steady_level[0], sl[i]);
         chk("ocb", {xenon_profile_off[0], alt_high_level_sel[0], overcurrent_mode_sel[0]}, {k[0], k[1], k[0]});
      end
      $display("test overcurrent done");
   endtask
   task automatic t_gcr;
      logic [1:0] k;
      // Output one on from the pulse register, so pulse control is visible
      frm(fw(1'h0, 1'h1, 1'h1, DSSC_A_PWM, 9'h080));
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         frm(fw(1'h0, 1'h0, 1'h0, DSSC_A_GCR, {k[1], k[0], 1'h1, k, 1'h1, k[0], 1'h0, k[1]}));
         chk("pwm", {vdd_fail_det_en, pwm_en, pwm_clk_internal, overvoltage_protect_off}, {k[1], k[0], k[0], k[1]});
         chk("sns", {sense_tristate, current_mirror_en, temp_report_en}, {i == 0, k[0], i == 2});
         chk("msel", {mirror_select_valid, mirror_output}, {1'h1, k[0]});
         chk("sw", switch_on, k[0] ? 2'h2 : 2'h3);
         @(posedge mclk) #1 vdd_fail = 1'h1;
         repeat (3) @(posedge mclk);
         #1 chk("swf", switch_on, k[1] ? 2'h2 : 2'h3);
         vdd_fail = 1'h0;
      end
      $display("test global done");
   endtask
   task automatic t_bad;
      logic [15:0] w1 = fw(1'h1, 1'h0, 1'h0, DSSC_A_GCR, 9'h000);
      logic [15:0] w2 = fw(1'h0, 1'h0, 1'h0, DSSC_A_CAL, 9'h15B);
      xf({16'h0000, w1}, 15);
      chk("short", overvoltage_protect_off, 1'h1);
      xf({w1, w2}, 32);
      chk("echo", rx[15:0], w1);
      chk("sel", rx[30:26], 5'h0B);
      chk("cal", cal_value, 9'h15B);
      chk("ov", overvoltage_protect_off, 1'h1);
      $display("test framing done");
   endtask
   task t_stat;
      flt0 = 6'h2D;
      @(posedge mclk) #1 por = 1'h1;
      @(posedge mclk) #1 por = 1'h0;
      frm(fw(1'h0, 1'h0, 1'h0, DSSC_A_STAT, 9'h000));
      frm(fw(1'h1, 1'h0, 1'h0, DSSC_A_STAT, 9'h005));
      chk("stat", rx[15:0], {1'h0, 5'h00, 1'h1, 9'h12D});
      flt0 = 6'h15;
      frm(fw(1'h0, 1'h0, 1'h0, DSSC_A_STAT, 9'h000));
      chk("gcrrd", rx[15:0], {1'h1, 5'h05, 1'h1, 9'h1FD});
      frm(fw(1'h0, 1'h0, 1'h0, DSSC_A_STAT, 9'h000));
      chk("stat2", rx[15:0], {1'h0, 5'h00, 1'h1, 9'h015});
      $display("test status done");
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1 sys_rst = 1'h0;
      repeat (6) @(posedge mclk);
      t_reset;
      t_fault;
      t_ocr;
      t_gcr;
      t_bad;
      t_stat;
      final_report;
   end
endmodule

// ===== verilog/dssc_if.sv
interface dssc_if;
   logic frame_done;
   logic frame_ok;
   logic in_frame;
   logic [15:0] frame_word;
   logic [15:0] load_word;
   modport shifter (output frame_done, frame_ok, in_frame, frame_word, input load_word);
   modport core (input frame_done, frame_ok, in_frame, frame_word, output load_word);
endinterface

// ===== verilog/dssc_pkg.sv
package dssc_pkg;
   // Frame layout
   localparam int DSSC_FRAME_BITS = 16;
   localparam int DSSC_WD_BIT = 15;
   localparam int DSSC_PFX_BIT = 14;
   localparam int DSSC_OUT_BIT = 13;
   localparam int DSSC_ADDR_HI = 12;
   localparam int DSSC_ADDR_LO = 10;
   localparam int DSSC_DATA_HI = 8;
   // Low address codes
   localparam logic [2:0] DSSC_A_STAT = 3'h0;
   localparam logic [2:0] DSSC_A_PWM = 3'h1;
   localparam logic [2:0] DSSC_A_CONF0 = 3'h2;
   localparam logic [2:0] DSSC_A_FAULT = 3'h3;
   localparam logic [2:0] DSSC_A_OC = 3'h4;
   localparam logic [2:0] DSSC_A_GCR = 3'h5;
   localparam logic [2:0] DSSC_A_CAL = 3'h7;
   // Fault-management fields
   localparam int DSSC_F_RETRY_UNL = 6;
   localparam int DSSC_F_RETRY_OFF = 5;
   localparam int DSSC_F_SHORT_OFF = 4;
   localparam int DSSC_F_OLON_OFF = 3;
   localparam int DSSC_F_OLOFF_OFF = 2;
   localparam int DSSC_F_LED_THR = 1;
   localparam int DSSC_F_RATIO = 0;
   // Overcurrent fields
   localparam int DSSC_O_XENON = 8;
   localparam int DSSC_O_COOL_HI = 7;
   localparam int DSSC_O_COOL_LO = 6;
   localparam int DSSC_O_INR_HI = 5;
   localparam int DSSC_O_INR_LO = 4;
   localparam int DSSC_O_ALT_HI = 3;
   localparam int DSSC_O_STDY_HI = 2;
   localparam int DSSC_O_STDY_LO = 1;
   localparam int DSSC_O_MODE = 0;
   // Global fields, then the pulse register on bit
   localparam int DSSC_G_VDD_EN = 8;
   localparam int DSSC_G_PWM_EN = 7;
   localparam int DSSC_G_CLK_SEL = 6;
   localparam int DSSC_G_TEMP = 5;
   localparam int DSSC_G_MIRROR = 4;
   localparam int DSSC_G_MSEL_HI = 3;
   localparam int DSSC_G_MSEL_LO = 2;
   localparam int DSSC_G_OV_OFF = 0;
   localparam int DSSC_P_ON = 7;
   // Readback selection
   localparam int DSSC_SEL_OUT_BIT = 3;
   localparam logic [4:0] DSSC_SEL_DIAG1 = 5'h0F;
   localparam logic [4:0] DSSC_SEL_DIAG2 = 5'h17;
   localparam logic [8:0] DSSC_DIAG2_VAL = 9'h002;
   localparam logic DSSC_NORMAL_MODE = 1'b1;
   // Reset values
   localparam logic [8:0] DSSC_REG_RST = 9'h000;
   localparam logic [4:0] DSSC_SEL_RST = 5'h00;
   localparam logic [2:0] DSSC_PIN_IDLE = 3'h2;
   // Pin vector order {sclk, chip_select_n, si}
   localparam int DSSC_PIN_SCK = 2;
   localparam int DSSC_PIN_CSN = 1;
   localparam int DSSC_PIN_SDI = 0;
   // Decoded speed and level codes
   localparam logic [1:0] DSSC_COOL_SLOW = 2'h0;
   localparam logic [1:0] DSSC_COOL_MED = 2'h1;
   localparam logic [1:0] DSSC_COOL_FAST = 2'h2;
   localparam logic [1:0] DSSC_INR_VSLOW = 2'h0;
   localparam logic [1:0] DSSC_INR_SLOW = 2'h1;
   localparam logic [1:0] DSSC_INR_MED = 2'h2;
   localparam logic [1:0] DSSC_INR_FAST = 2'h3;
   localparam logic [1:0] DSSC_LVL1 = 2'h0;
   localparam logic [1:0] DSSC_LVL2 = 2'h1;
   localparam logic [1:0] DSSC_LVL3 = 2'h2;
   localparam logic [1:0] DSSC_LVL4 = 2'h3;
endpackage

// ===== verilog/dssc_shift.sv
module dssc_shift
   import dssc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   dssc_if.shifter lnk
);
   typedef enum {DSSC_IDLE, DSSC_SHIFT} dssc_state_t;
   dssc_state_t state_q, state_d;
   logic [2:0] a_q, b_q, c_q, filt_q, prev_q, filt_d;
   logic [15:0] sh_q, sh_d, word_q, word_d;
   logic [3:0] cnt_q, cnt_d;
   logic full_q, full_d, so_q, so_d, done_q, done_d, ok_q, ok_d;
   logic sck_rise, sck_fall, cs_fall, cs_rise;

   always_comb begin
      // Second and third stages must agree before a pin change counts
      filt_d = (filt_q & (b_q ^ c_q)) | (c_q & ~(b_q ^ c_q));
      sck_rise = filt_q[DSSC_PIN_SCK] & ~prev_q[DSSC_PIN_SCK];
      sck_fall = ~filt_q[DSSC_PIN_SCK] & prev_q[DSSC_PIN_SCK];
      cs_fall = ~filt_q[DSSC_PIN_CSN] & prev_q[DSSC_PIN_CSN];
      cs_rise = filt_q[DSSC_PIN_CSN] & ~prev_q[DSSC_PIN_CSN];
      state_d = state_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      full_d = full_q;
      so_d = so_q;
      done_d = 1'b0;
      ok_d = ok_q;
      word_d = word_q;
      case (state_q)
         DSSC_IDLE: begin
            if (cs_fall) begin
               state_d = DSSC_SHIFT;
               sh_d = lnk.load_word;
               so_d = lnk.load_word[DSSC_FRAME_BITS-1];
               cnt_d = 4'h0;
               full_d = 1'b0;
            end
         end
         DSSC_SHIFT: begin
            if (cs_rise) begin
               state_d = DSSC_IDLE;
               done_d = 1'b1;
               ok_d = full_q && (cnt_q == 4'h0);
               word_d = sh_q;
            end else begin
               // one register both returns and receives
               if (sck_rise) begin
                  sh_d = {sh_q[14:0], filt_q[DSSC_PIN_SDI]};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'hF) begin
                     full_d = 1'b1;
                  end
               end
               if (sck_fall) begin
                  so_d = sh_q[DSSC_FRAME_BITS-1];
               end
            end
         end
         default: state_d = DSSC_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         a_q <= DSSC_PIN_IDLE;
         b_q <= DSSC_PIN_IDLE;
         c_q <= DSSC_PIN_IDLE;
         filt_q <= DSSC_PIN_IDLE;
         prev_q <= DSSC_PIN_IDLE;
         state_q <= DSSC_IDLE;
         sh_q <= 16'h0000;
         cnt_q <= 4'h0;
         full_q <= 1'b0;
         so_q <= 1'b0;
         done_q <= 1'b0;
         ok_q <= 1'b0;
         word_q <= 16'h0000;
      end else begin
         a_q <= {sclk, chip_select_n, si};
         b_q <= a_q;
         c_q <= b_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
         state_q <= state_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
         so_q <= so_d;
         done_q <= done_d;
         ok_q <= ok_d;
         word_q <= word_d;
      end
   end

   assign so = so_q;
   assign so_oe_n = (state_q == DSSC_IDLE);
   assign lnk.in_frame = (state_q == DSSC_SHIFT);
   assign lnk.frame_done = done_q;
   assign lnk.frame_ok = ok_q;
   assign lnk.frame_word = word_q;

   so_release_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (state_q == DSSC_SHIFT && cs_rise) |=> so_oe_n && lnk.frame_done)
      else $error("serial output not released at frame end");
   first_bit_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (state_q == DSSC_IDLE && cs_fall) |=> !so_oe_n && so == $past(lnk.load_word[15]))
      else $error("first returned bit is not the loaded top bit");
   bad_length_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (state_q == DSSC_SHIFT && cs_rise && cnt_q != 4'h0) |=> lnk.frame_done && !lnk.frame_ok)
      else $error("frame of bad length accepted");
   echo_bit_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (state_q == DSSC_SHIFT && !cs_rise && sck_fall && full_q) |=> so == $past(sh_q[15]))
      else $error("daisy chain bit not returned");
endmodule

// ===== verilog/dssc_top.sv
module dssc_top
   import dssc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   input wire logic [1:0] direct_in,
   input wire logic vdd_fail,
   input wire logic por_event,
   input wire logic uv_flag,
   input wire logic ov_flag,
   input wire logic [5:0] fault_flags_zero,
   input wire logic [5:0] fault_flags_one,
   output logic [1:0] switch_on,
   output logic [1:0] retry_limit_off,
   output logic [1:0] retry_off,
   output logic [1:0] supply_short_protect_off,
   output logic [1:0] on_openload_off,
   output logic [1:0] led_openload_threshold,
   output logic [1:0] off_openload_off,
   output logic [1:0] sense_ratio_high,
   output logic [1:0] xenon_profile_off,
   output logic [1:0][1:0] cooling_speed,
   output logic [1:0][1:0] inrush_speed,
   output logic [1:0] alt_high_level_sel,
   output logic [1:0][1:0] steady_level,
   output logic [1:0] overcurrent_mode_sel,
   output logic vdd_fail_det_en,
   output logic pwm_en,
   output logic pwm_clk_internal,
   output logic sense_tristate,
   output logic current_mirror_en,
   output logic temp_report_en,
   output logic mirror_output,
   output logic mirror_select_valid,
   output logic overvoltage_protect_off,
   output logic [8:0] cal_value
);
   function automatic logic [1:0] cool_code(input logic [1:0] c);
      case (c)
         2'h1: cool_code = DSSC_COOL_SLOW;
         2'h2: cool_code = DSSC_COOL_FAST;
         default: cool_code = DSSC_COOL_MED;
      endcase
   endfunction

   function automatic logic [1:0] inrush_code(input logic [1:0] c);
      case (c)
         2'h1: inrush_code = DSSC_INR_FAST;
         2'h2: inrush_code = DSSC_INR_MED;
         2'h3: inrush_code = DSSC_INR_VSLOW;
         default: inrush_code = DSSC_INR_SLOW;
      endcase
   endfunction

   function automatic logic [1:0] steady_code(input logic [1:0] c);
      case (c)
         2'h1: steady_code = DSSC_LVL3;
         2'h2: steady_code = DSSC_LVL4;
         2'h3: steady_code = DSSC_LVL1;
         default: steady_code = DSSC_LVL2;
      endcase
   endfunction

   dssc_if lnk ();

   dssc_shift u_shift (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .sclk(sclk),
      .chip_select_n(chip_select_n),
      .si(si),
      .so(so),
      .so_oe_n(so_oe_n),
      .lnk(lnk.shifter)
   );

   logic [1:0][8:0] fault_q, fault_d, oc_q, oc_d, pwm_q, pwm_d;
   logic [8:0] gcr_q, gcr_d, cal_q, cal_d, rb_data;
   logic [4:0] sel_q, sel_d;
   logic wd_q, wd_d, por_q, por_d;
   logic [13:0] snap_q, snap_d;
   logic [1:0] switch_q, switch_d, pwm_on;
   logic wr;
   logic [2:0] addr;
   logic tgt;
   logic [8:0] data;
   logic [5:0] flags_sel;

   assign wr = lnk.frame_done & lnk.frame_ok;
   assign addr = lnk.frame_word[DSSC_ADDR_HI:DSSC_ADDR_LO];
   assign tgt = lnk.frame_word[DSSC_OUT_BIT];
   assign data = lnk.frame_word[DSSC_DATA_HI:0];

   always_comb begin
      fault_d = fault_q;
      oc_d = oc_q;
      pwm_d = pwm_q;
      gcr_d = gcr_q;
      cal_d = cal_q;
      sel_d = sel_q;
      wd_d = wd_q;
      por_d = por_q;
      // fresh fault status only between frames
      snap_d = snap_q;
      if (!lnk.in_frame) begin
         snap_d = {uv_flag, ov_flag, fault_flags_one, fault_flags_zero};
      end
      if (wr) begin
         wd_d = lnk.frame_word[DSSC_WD_BIT];
         // Status read acknowledges the power-on flag
         if (sel_q[2:0] == DSSC_A_STAT) begin
            por_d = 1'b0;
         end
         if (lnk.frame_word[DSSC_PFX_BIT]) begin
            // output picked by frame bit 13
            case (addr)
               DSSC_A_STAT: sel_d = lnk.frame_word[4:0];
               DSSC_A_PWM: pwm_d[tgt] = data;
               DSSC_A_FAULT: fault_d[tgt] = data;
               DSSC_A_OC: oc_d[tgt] = data;
               default: sel_d = sel_q;
            endcase
         end else begin
            case (addr)
               // selection persists until next status write
               DSSC_A_STAT: sel_d = lnk.frame_word[4:0];
               DSSC_A_GCR: gcr_d = data;
               DSSC_A_CAL: cal_d = data;
               default: sel_d = sel_q;
            endcase
         end
      end
      // Power-on event wins over a same-cycle acknowledge
      if (por_event) begin
         por_d = 1'b1;
      end
   end

   always_comb begin
      pwm_on = {pwm_q[1][DSSC_P_ON], pwm_q[0][DSSC_P_ON]};
      // fail-safe keeps pulse control only when detector enabled
      if (vdd_fail) begin
         switch_d = gcr_q[DSSC_G_VDD_EN] ? pwm_on : direct_in;
      end else if (gcr_q[DSSC_G_PWM_EN]) begin
         switch_d = pwm_on;
      end else begin
         switch_d = direct_in | pwm_on;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fault_q <= {DSSC_REG_RST, DSSC_REG_RST};
         oc_q <= {DSSC_REG_RST, DSSC_REG_RST};
         pwm_q <= {DSSC_REG_RST, DSSC_REG_RST};
         gcr_q <= DSSC_REG_RST;
         cal_q <= DSSC_REG_RST;
         sel_q <= DSSC_SEL_RST;
         wd_q <= 1'b0;
         por_q <= 1'b0;
         snap_q <= 14'h0000;
         switch_q <= 2'h0;
      end else begin
         fault_q <= fault_d;
         oc_q <= oc_d;
         pwm_q <= pwm_d;
         gcr_q <= gcr_d;
         cal_q <= cal_d;
         sel_q <= sel_d;
         wd_q <= wd_d;
         por_q <= por_d;
         snap_q <= snap_d;
         switch_q <= switch_d;
      end
   end

   always_comb begin
      flags_sel = sel_q[DSSC_SEL_OUT_BIT] ? snap_q[11:6] : snap_q[5:0];
      case (sel_q[2:0])
         DSSC_A_STAT: rb_data = {por_q, snap_q[13:12], flags_sel};
         DSSC_A_PWM: rb_data = pwm_q[sel_q[DSSC_SEL_OUT_BIT]];
         DSSC_A_FAULT: rb_data = fault_q[sel_q[DSSC_SEL_OUT_BIT]];
         DSSC_A_OC: rb_data = oc_q[sel_q[DSSC_SEL_OUT_BIT]];
         DSSC_A_GCR: rb_data = gcr_q;
         DSSC_A_CAL: begin
            if (sel_q == DSSC_SEL_DIAG1) begin
               rb_data = {4'h0, direct_in, 3'h0};
            end else if (sel_q == DSSC_SEL_DIAG2) begin
               rb_data = DSSC_DIAG2_VAL;
            end else begin
               rb_data = 9'h000;
            end
         end
         default: rb_data = 9'h000;
      endcase
   end
   assign lnk.load_word = {wd_q, sel_q, DSSC_NORMAL_MODE, rb_data};

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         retry_limit_off[i] = fault_q[i][DSSC_F_RETRY_UNL];
         retry_off[i] = fault_q[i][DSSC_F_RETRY_OFF];
         supply_short_protect_off[i] = fault_q[i][DSSC_F_SHORT_OFF];
         on_openload_off[i] = fault_q[i][DSSC_F_OLON_OFF];
         led_openload_threshold[i] = ~fault_q[i][DSSC_F_OLON_OFF] & fault_q[i][DSSC_F_LED_THR];
         off_openload_off[i] = fault_q[i][DSSC_F_OLOFF_OFF];
         sense_ratio_high[i] = fault_q[i][DSSC_F_RATIO];
         xenon_profile_off[i] = oc_q[i][DSSC_O_XENON];
         cooling_speed[i] = cool_code(oc_q[i][DSSC_O_COOL_HI:DSSC_O_COOL_LO]);
         inrush_speed[i] = inrush_code(oc_q[i][DSSC_O_INR_HI:DSSC_O_INR_LO]);
         alt_high_level_sel[i] = oc_q[i][DSSC_O_ALT_HI];
         steady_level[i] = steady_code(oc_q[i][DSSC_O_STDY_HI:DSSC_O_STDY_LO]);
         overcurrent_mode_sel[i] = oc_q[i][DSSC_O_MODE];
      end
   end

   assign switch_on = switch_q;
   assign vdd_fail_det_en = gcr_q[DSSC_G_VDD_EN];
   assign pwm_en = gcr_q[DSSC_G_PWM_EN];
   // clock choice ignored while module off
   assign pwm_clk_internal = gcr_q[DSSC_G_PWM_EN] & gcr_q[DSSC_G_CLK_SEL];
   assign current_mirror_en = gcr_q[DSSC_G_MIRROR];
   assign temp_report_en = gcr_q[DSSC_G_TEMP] & ~gcr_q[DSSC_G_MIRROR];
   assign sense_tristate = ~gcr_q[DSSC_G_TEMP] & ~gcr_q[DSSC_G_MIRROR];
   // mirror selection; codes 0x leave it undefined
   assign mirror_output = gcr_q[DSSC_G_MSEL_LO];
   assign mirror_select_valid = gcr_q[DSSC_G_MSEL_HI];
   assign overvoltage_protect_off = gcr_q[DSSC_G_OV_OFF];
   assign cal_value = cal_q;

   fault_write_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr && lnk.frame_word[14] && !tgt && addr == DSSC_A_FAULT)
      |=> fault_q[0] == $past(data) && retry_limit_off[0] == $past(data[6]))
      else $error("fault config write to output zero lost");
   target_sel_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr && lnk.frame_word[14] && tgt && addr == DSSC_A_OC)
      |=> oc_q[1] == $past(data) && $stable(oc_q[0]))
      else $error("overcurrent write hit the wrong output");
   bad_frame_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (lnk.frame_done && !lnk.frame_ok)
      |=> $stable(sel_q) && $stable(gcr_q) && $stable(fault_q) && $stable(cal_q))
      else $error("invalid frame changed a register");
   sel_keep_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr && addr != DSSC_A_STAT) |=> $stable(sel_q))
      else $error("selection changed without status write");
   steady_map_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (oc_q[0][2:1] == 2'h3) |-> steady_level[0] == DSSC_LVL1)
      else $error("steady limit decode wrong");
   pwm_drive_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (gcr_q[7] && !vdd_fail) |=> switch_on == $past({pwm_q[1][7], pwm_q[0][7]}))
      else $error("outputs not driven from pulse register");
   clk_sel_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !gcr_q[7] |-> !pwm_clk_internal)
      else $error("clock choice active with module off");
endmodule
